/* File: logic/udlr_pkg.sv */
// Package of constants for the USB DMA lockup recovery block
package udlr_pkg;
    localparam logic [11:0] ADDR_CTRL    = 12'h000;
    localparam logic [11:0] ADDR_STATUS  = 12'h004;
    localparam logic [11:0] ADDR_IRQ_ST  = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MSK = 12'h00C;
    localparam logic [11:0] ADDR_T2_CNT  = 12'h010;
    localparam logic [11:0] ADDR_T1_CNT  = 12'h014;
    localparam logic [11:0] ADDR_EXPECT  = 12'h018;
    localparam logic [11:0] ADDR_EVENT   = 12'h01C;
    localparam int CLK_HZ       = 20000000;
    localparam int T2_MS        = 40;
    localparam int T2_MAX_MS    = 50;
    localparam int T1_MS        = 200;
    localparam int T2_CYCLES    = (CLK_HZ / 1000) * T2_MS;
    localparam int T2_MAX_CYC   = (CLK_HZ / 1000) * T2_MAX_MS - 1;
    localparam int T1_CYCLES    = (CLK_HZ / 1000) * T1_MS;
    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_DEV_BIT = 1;
    localparam int IRQ_OK_BIT   = 0;
    localparam int IRQ_HUNG_BIT = 1;
    localparam int IRQ_DONE_BIT = 2;
    localparam int IRQ_W        = 3;
    localparam logic [31:0] EXPECT_RESET = 32'hA5A5_5A5A;
    typedef enum logic [7:0] {
        UDLR_IDLE   = 8'h01,
        UDLR_ARMED  = 8'h02,
        UDLR_START  = 8'h04,
        UDLR_WAIT   = 8'h08,
        UDLR_CHECK  = 8'h10,
        UDLR_DISC   = 8'h20,
        UDLR_RESET  = 8'h40,
        UDLR_SETUP  = 8'h80
    } udlr_state_t;
endpackage

/* File: logic/udlr_timer.sv */
// Down counter used for the test and disconnect delay timers
`timescale 1ns/100ps
`default_nettype none
module udlr_timer #(
    parameter int W = 32
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         start,
    input  wire logic         stop,
    input  wire logic [W-1:0] load,
    output logic              expired,
    output logic              running
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_expired;
    logic         next_running;

    if (W < 2) begin : g_bad_w
        $error("timer width below two bits");
    end

    always_comb begin
        next_cnt     = cnt;
        next_running = running;
        next_expired = 1'b0;
        if (stop) begin
            next_running = 1'b0;
        end else if (start) begin
            next_cnt     = (load == '0) ? {{(W-1){1'b0}}, 1'b1} : load;
            next_running = 1'b1;
        end else if (running) begin
            next_cnt = cnt - {{(W-1){1'b0}}, 1'b1};
            if (cnt == {{(W-1){1'b0}}, 1'b1}) begin
                next_running = 1'b0;
                next_expired = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt     <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            running <= next_running;
            expired <= next_expired;
        end
    end
endmodule // udlr_timer
`default_nettype wire

/* File: logic/udlr_core.sv */
// USB DMA lockup detection and recovery sequencer with APB registers
// What this block does
// R01: Bus reset during active DMA may lock the master; arm detection.
// R02: Only a full subsystem reset clears a locked master.
// R03: Detection only runs in device mode, at any link speed.
// R04: Locked master blocks enumeration; recovery restores it.
// R05: On first missing-descriptor event, idle master tests, busy recovers.
// R06: Dummy IN1 test: setup request then doorbell ring.
// R07: Test timer under 50 ms, 40 ms default; expiry means recovery.
// R08: On completion compare buffer data; mismatch means recovery.
// R09: Recovery forces disconnect then starts delay of at least 200 ms.
// R10: Delay terminal count programmable upward for longer downtime.
// R11: Reset subsystem, wait delay, then request device-mode setup.
// R12: Timers are clock counters; extra missing events ignored meanwhile.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module udlr_core #(
    parameter int T1_FLOOR = udlr_pkg::T1_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bus_reset,
    input  wire logic        desc_missing,
    input  wire logic        master_idle,
    input  wire logic        completion_interrupt,
    input  wire logic [31:0] buf_data,
    input  wire logic        setup_done,
    output logic             test_setup_req,
    output logic             doorbell_in1,
    output logic             force_disconnect,
    output logic             subsys_reset,
    output logic             device_setup_req,
    output logic             irq
);
    localparam logic [31:0] T2_DEF = 32'(udlr_pkg::T2_CYCLES);
    localparam logic [31:0] T2_MAX = 32'(udlr_pkg::T2_MAX_CYC);
    localparam logic [31:0] T1_MIN = 32'(T1_FLOOR);

    if (T1_FLOOR < 1) begin : g_bad_floor
        $error("delay floor must be positive");
    end

    udlr_pkg::udlr_state_t state;
    udlr_pkg::udlr_state_t next_state;
    logic [1:0]  ctrl;
    logic [1:0]  next_ctrl;
    logic [udlr_pkg::IRQ_W-1:0] irq_st;
    logic [udlr_pkg::IRQ_W-1:0] next_irq_st;
    logic [udlr_pkg::IRQ_W-1:0] irq_msk;
    logic [udlr_pkg::IRQ_W-1:0] next_irq_msk;
    logic [udlr_pkg::IRQ_W-1:0] ev;
    logic [31:0] t2_cnt;
    logic [31:0] next_t2_cnt;
    logic [31:0] t1_cnt;
    logic [31:0] next_t1_cnt;
    logic [31:0] expect_val;
    logic [31:0] next_expect_val;
    logic [7:0]  recov_cnt;
    logic [7:0]  next_recov_cnt;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        next_test_setup;
    logic        next_doorbell;
    logic        next_disc;
    logic        next_sreset;
    logic        next_dsetup;
    logic        t2_start;
    logic        t1_start;
    logic        t2_exp;
    logic        t1_exp;
    logic        t1_run;
    logic        wr_acc;
    logic        rd_acc;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        return a == o;
    endfunction

    assign wr_acc = psel && penable && pwrite && !pready;
    assign rd_acc = psel && penable && !pwrite && !pready;

    udlr_timer #(.W(32)) u_dummy_test_timer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .start   (t2_start),
        .stop    (completion_interrupt),
        .load    (t2_cnt),
        .expired (t2_exp),
        .running ()
    );

    udlr_timer #(.W(32)) u_disconnect_delay_timer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .start   (t1_start),
        .stop    (1'b0),
        .load    (t1_cnt),
        .expired (t1_exp),
        .running (t1_run)
    );

    // Sequencer
    always_comb begin
        next_state      = state;
        t2_start        = 1'b0;
        t1_start        = 1'b0;
        ev              = '0;
        next_test_setup = 1'b0;
        next_doorbell   = 1'b0;
        next_disc       = force_disconnect;
        next_sreset     = 1'b0;
        next_dsetup     = device_setup_req;
        next_recov_cnt  = recov_cnt;
        case (state)
            udlr_pkg::UDLR_IDLE: begin
                if (ctrl[udlr_pkg::CTRL_EN_BIT]
                    && ctrl[udlr_pkg::CTRL_DEV_BIT] && bus_reset) begin
                    next_state = udlr_pkg::UDLR_ARMED; // R01 R03
                end
            end
            udlr_pkg::UDLR_ARMED: begin
                if (!ctrl[udlr_pkg::CTRL_DEV_BIT]) begin
                    next_state = udlr_pkg::UDLR_IDLE; // R03
                end else if (desc_missing) begin
                    if (master_idle) begin
                        next_state      = udlr_pkg::UDLR_START; // R05
                        next_test_setup = 1'b1; // R06
                    end else begin
                        next_state = udlr_pkg::UDLR_DISC; // R05
                    end
                end
            end
            udlr_pkg::UDLR_START: begin
                next_doorbell = 1'b1; // R06
                t2_start      = 1'b1; // R07 R12
                next_state    = udlr_pkg::UDLR_WAIT;
            end
            udlr_pkg::UDLR_WAIT: begin
                if (completion_interrupt) begin
                    next_state = udlr_pkg::UDLR_CHECK;
                end else if (t2_exp) begin
                    next_state = udlr_pkg::UDLR_DISC; // R07
                end
            end
            udlr_pkg::UDLR_CHECK: begin
                if (buf_data == expect_val) begin
                    next_state = udlr_pkg::UDLR_IDLE; // R08
                    ev[udlr_pkg::IRQ_OK_BIT] = 1'b1;
                end else begin
                    next_state = udlr_pkg::UDLR_DISC; // R08
                end
            end
            udlr_pkg::UDLR_DISC: begin
                next_disc  = 1'b1; // R09
                t1_start   = 1'b1; // R09 R10
                next_state = udlr_pkg::UDLR_RESET;
                ev[udlr_pkg::IRQ_HUNG_BIT] = 1'b1;
                next_recov_cnt = recov_cnt + 8'h01;
            end
            udlr_pkg::UDLR_RESET: begin
                next_sreset = !t1_exp; // R02 R11
                if (t1_exp) begin
                    next_state  = udlr_pkg::UDLR_SETUP; // R11
                    next_disc   = 1'b0;
                    next_dsetup = 1'b1; // R04 R11
                end
            end
            udlr_pkg::UDLR_SETUP: begin
                if (setup_done) begin
                    next_dsetup = 1'b0;
                    next_state  = udlr_pkg::UDLR_IDLE;
                    ev[udlr_pkg::IRQ_DONE_BIT] = 1'b1;
                end
            end
            default: next_state = udlr_pkg::UDLR_IDLE;
        endcase
    end

    // APB registers
    always_comb begin
        next_ctrl       = ctrl;
        next_irq_msk    = irq_msk;
        next_t2_cnt     = t2_cnt;
        next_t1_cnt     = t1_cnt;
        next_expect_val = expect_val;
        next_irq_st     = irq_st;
        next_pready     = psel && penable && !pready;
        next_pslverr    = 1'b0;
        next_prdata     = '0;
        if (wr_acc) begin
            if (hit(paddr, udlr_pkg::ADDR_CTRL)) begin
                next_ctrl = pwdata[1:0];
            end else if (hit(paddr, udlr_pkg::ADDR_IRQ_ST)) begin
                next_irq_st = irq_st & ~pwdata[udlr_pkg::IRQ_W-1:0];
            end else if (hit(paddr, udlr_pkg::ADDR_IRQ_MSK)) begin
                next_irq_msk = pwdata[udlr_pkg::IRQ_W-1:0];
            end else if (hit(paddr, udlr_pkg::ADDR_T2_CNT)) begin
                next_t2_cnt = (pwdata > T2_MAX) ? T2_MAX : pwdata; // R07 R12
            end else if (hit(paddr, udlr_pkg::ADDR_T1_CNT)) begin
                next_t1_cnt = (pwdata < T1_MIN) ? T1_MIN : pwdata; // R09 R10
            end else if (hit(paddr, udlr_pkg::ADDR_EXPECT)) begin
                next_expect_val = pwdata;
            end else if (!hit(paddr, udlr_pkg::ADDR_STATUS)) begin
                next_pslverr = 1'b1;
            end
        end
        if (rd_acc) begin
            if (hit(paddr, udlr_pkg::ADDR_CTRL)) begin
                next_prdata = {30'h0, ctrl};
            end else if (hit(paddr, udlr_pkg::ADDR_STATUS)) begin
                next_prdata = {15'h0, t1_run, recov_cnt, state};
            end else if (hit(paddr, udlr_pkg::ADDR_IRQ_ST)) begin
                next_prdata = {29'h0, irq_st};
            end else if (hit(paddr, udlr_pkg::ADDR_IRQ_MSK)) begin
                next_prdata = {29'h0, irq_msk};
            end else if (hit(paddr, udlr_pkg::ADDR_T2_CNT)) begin
                next_prdata = t2_cnt;
            end else if (hit(paddr, udlr_pkg::ADDR_T1_CNT)) begin
                next_prdata = t1_cnt;
            end else if (hit(paddr, udlr_pkg::ADDR_EXPECT)) begin
                next_prdata = expect_val;
            end else begin
                next_pslverr = 1'b1;
            end
        end
        next_irq_st = next_irq_st | ev;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state            <= udlr_pkg::UDLR_IDLE;
            ctrl             <= 2'h0;
            irq_st           <= '0;
            irq_msk          <= '0;
            t2_cnt           <= T2_DEF;
            t1_cnt           <= T1_MIN;
            expect_val       <= udlr_pkg::EXPECT_RESET;
            recov_cnt        <= 8'h00;
            prdata           <= 32'h0000_0000;
            pready           <= 1'b0;
            pslverr          <= 1'b0;
            test_setup_req   <= 1'b0;
            doorbell_in1     <= 1'b0;
            force_disconnect <= 1'b0;
            subsys_reset     <= 1'b0;
            device_setup_req <= 1'b0;
            irq              <= 1'b0;
        end else begin
            state            <= next_state;
            ctrl             <= next_ctrl;
            irq_st           <= next_irq_st;
            irq_msk          <= next_irq_msk;
            t2_cnt           <= next_t2_cnt;
            t1_cnt           <= next_t1_cnt;
            expect_val       <= next_expect_val;
            recov_cnt        <= next_recov_cnt;
            prdata           <= next_prdata;
            pready           <= next_pready;
            pslverr          <= next_pslverr;
            test_setup_req   <= next_test_setup;
            doorbell_in1     <= next_doorbell;
            force_disconnect <= next_disc;
            subsys_reset     <= next_sreset;
            device_setup_req <= next_dsetup;
            irq              <= |(next_irq_st & next_irq_msk);
        end
    end

    a_busy_recover: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == udlr_pkg::UDLR_ARMED && desc_missing && !master_idle
        && ctrl[udlr_pkg::CTRL_DEV_BIT] |=> ##1 force_disconnect) // R05
        else $error("busy master did not disconnect");
    a_ring_after_setup: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(test_setup_req) |=> doorbell_in1) // R06
        else $error("doorbell did not follow test setup");
    a_ignore_missing: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == udlr_pkg::UDLR_WAIT && !completion_interrupt && !t2_exp
        |=> state == udlr_pkg::UDLR_WAIT) // R12
        else $error("wait left without cause");
    a_timeout_hung: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == udlr_pkg::UDLR_WAIT && t2_exp && !completion_interrupt
        |=> ##1 force_disconnect) // R07
        else $error("test timeout did not recover");
    a_bad_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == udlr_pkg::UDLR_CHECK && buf_data != expect_val
        |=> ##1 force_disconnect ##1 subsys_reset) // R08
        else $error("bad data did not recover");
    a_t1_floor: assert property (@(posedge sys_clk) disable iff (!rst_n)
        t1_cnt >= T1_MIN) // R09
        else $error("delay below minimum");
    a_reset_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(subsys_reset) |-> force_disconnect && t1_run) // R11
        else $error("subsystem reset without disconnect");
    a_setup_after: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(device_setup_req) |-> $past(t1_exp)) // R11
        else $error("setup before delay end");
endmodule // udlr_core
`default_nettype wire

/* File: tb/udlr_usb_model.sv */
// Behavioural USB controller and DMA master facing the recovery block
`timescale 1ns/100ps
`default_nettype none
module udlr_usb_model (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        bus_reset,
    input  wire logic        dma_active,
    input  wire logic        dev_mode,
    input  wire logic        good,
    input  wire logic [31:0] payload,
    input  wire logic [3:0]  dly,
    input  wire logic        test_setup_req,
    input  wire logic        doorbell_in1,
    input  wire logic        subsys_reset,
    input  wire logic        device_setup_req,
    output logic             master_idle,
    output logic             completion_interrupt,
    output logic [31:0]      buf_data,
    output logic             setup_done
);
    logic       hung = 1'b0;
    logic       armed = 1'b0;
    logic [3:0] cnt = 4'h0;
    logic [2:0] hv = 3'h0;
    initial completion_interrupt = 1'b0;
    initial buf_data = 32'h0;
    initial setup_done = 1'b0;
    assign master_idle = ~dma_active;
    always @(posedge sys_clk) begin
        if (!rst_n || subsys_reset) begin
            hung <= 1'b0;
        end else if (bus_reset && dma_active && dev_mode) begin
            hung <= 1'b1;
        end
        if (test_setup_req) begin
            armed <= 1'b1;
        end
        if (doorbell_in1 && armed && !hung) begin
            cnt   <= dly;
            armed <= 1'b0;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
        completion_interrupt <= (cnt == 4'h1);
        if (cnt == 4'h1) begin
            buf_data <= good ? payload : ~payload;
            hv       <= 3'h4;
        end else if (hv != 3'h0) begin
            hv <= hv - 3'h1;
        end else begin
            buf_data <= ~buf_data;
        end
        setup_done <= device_setup_req & ~setup_done;
    end
endmodule // udlr_usb_model
`default_nettype wire

/* File: tb/test_usb_dma_lockup_recovery.sv */
// Self-checking bench of the USB DMA lockup recovery block
`timescale 1ns/100ps
`default_nettype none
module test_usb_dma_lockup_recovery;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        bus_reset = 1'b0;
    logic        desc_missing = 1'b0;
    logic        master_idle;
    logic        completion_interrupt;
    logic [31:0] buf_data;
    logic        setup_done;
    logic        test_setup_req;
    logic        doorbell_in1;
    logic        force_disconnect;
    logic        subsys_reset;
    logic        device_setup_req;
    logic        irq;
    logic        dma_active = 1'b0;
    logic        dev_mode = 1'b1;
    logic        good = 1'b1;
    logic [31:0] payload = 32'h0;
    logic [3:0]  dly = 4'h1;
    integer      seed;
    int          errors = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          n_setup = 0;
    int          t_setup = 0;
    int          t_bell = 0;
    int          t_disc = 0;
    logic [31:0] r;
    logic        e;
    int          n_sr = 0;
    localparam int T1F = 400;

    udlr_core #(.T1_FLOOR(T1F)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bus_reset(bus_reset), .desc_missing(desc_missing),
        .master_idle(master_idle),
        .completion_interrupt(completion_interrupt), .buf_data(buf_data),
        .setup_done(setup_done), .test_setup_req(test_setup_req),
        .doorbell_in1(doorbell_in1), .force_disconnect(force_disconnect),
        .subsys_reset(subsys_reset), .device_setup_req(device_setup_req),
        .irq(irq));

    udlr_usb_model far (.sys_clk(sys_clk), .rst_n(rst_n),
        .bus_reset(bus_reset), .dma_active(dma_active), .dev_mode(dev_mode),
        .good(good), .payload(payload), .dly(dly),
        .test_setup_req(test_setup_req), .doorbell_in1(doorbell_in1),
        .subsys_reset(subsys_reset), .device_setup_req(device_setup_req),
        .master_idle(master_idle),
        .completion_interrupt(completion_interrupt), .buf_data(buf_data),
        .setup_done(setup_done));

    always #25 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (test_setup_req === 1'b1) begin
            n_setup <= n_setup + 1;
            t_setup <= cyc;
        end
        if (doorbell_in1 === 1'b1) begin
            t_bell <= cyc;
        end
        if (force_disconnect !== 1'b1) begin
            t_disc <= cyc;
        end
        if (subsys_reset === 1'b1) begin
            n_sr <= n_sr + 1;
        end
    end

    task automatic final_report;
        $display("errors=%0d checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] exp_irq(input int m);
        return (m == 0) ? 32'h1 : 32'h2;
    endfunction

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(r, exp);
        check({31'h0, e}, 32'h0);
    endtask

    task automatic pulse_bus;
        @(posedge sys_clk);
        bus_reset <= 1'b1;
        @(posedge sys_clk);
        bus_reset <= 1'b0;
    endtask

    task automatic pulse_desc;
        @(posedge sys_clk);
        desc_missing <= 1'b1;
        @(posedge sys_clk);
        desc_missing <= 1'b0;
    endtask

    task automatic reset_dut;
        rst_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask

    task automatic round(input int m);
        logic [31:0] ev;
        int          ns0;
        int          nsr0;
        int          k;
        reset_dut();
        ev = $random(seed);
        payload    <= ev;
        good       <= (m != 2);
        dly        <= {1'b0, 3'($random(seed))} + 4'h1;
        dma_active <= (m == 1 || m == 3);
        apb(1'b1, udlr_pkg::ADDR_CTRL, 32'h3);
        apb(1'b1, udlr_pkg::ADDR_T2_CNT, 32'd20);
        apb(1'b1, udlr_pkg::ADDR_IRQ_MSK, (m == 2) ? 32'h5 : 32'h7);
        apb(1'b1, udlr_pkg::ADDR_EXPECT, ev);
        ns0 = n_setup;
        nsr0 = n_sr;
        pulse_desc();
        repeat (5) @(posedge sys_clk);
        check(n_setup - ns0, 32'h0);
        pulse_bus();
        if (m == 1) dma_active <= 1'b0;
        pulse_desc();
        pulse_desc();
        for (int i = 0; i < 300 && irq !== 1'b1 && force_disconnect !== 1'b1;
             i++) @(posedge sys_clk);
        check(n_setup - ns0, (m != 3) ? 32'h1 : 32'h0);
        if (m != 3) check(t_bell - t_setup, 32'h1);
        rd(udlr_pkg::ADDR_IRQ_ST, exp_irq(m));
        check({31'h0, irq}, {31'h0, m != 2});
        if (m == 0) begin
            apb(1'b1, udlr_pkg::ADDR_IRQ_ST, 32'h1);
            rd(udlr_pkg::ADDR_IRQ_ST, 32'h0);
            check({31'h0, irq | force_disconnect}, 32'h0);
        end else begin
            if (m == 1) check({31'h0, t_disc - t_bell >= 19}, 32'h1);
            repeat (100) @(posedge sys_clk);
            check({30'h0, force_disconnect, subsys_reset}, 32'h3);
            for (k = 0; k < 1000 && device_setup_req !== 1'b1; k++)
                @(posedge sys_clk);
            check(n_sr - nsr0, T1F);
            rd(udlr_pkg::ADDR_IRQ_ST, 32'h6);
            rd(udlr_pkg::ADDR_STATUS,
               {16'h0, 8'h01, udlr_pkg::UDLR_IDLE});
            check({29'h0, force_disconnect, subsys_reset,
                   device_setup_req}, 32'h0);
        end
    endtask

    initial begin
        seed = 32'h7e6a4ae7;
        reset_dut();
        rd(udlr_pkg::ADDR_T2_CNT, udlr_pkg::T2_CYCLES);
        rd(udlr_pkg::ADDR_T1_CNT, T1F);
        rd(udlr_pkg::ADDR_EXPECT, udlr_pkg::EXPECT_RESET);
        apb(1'b1, udlr_pkg::ADDR_T1_CNT, 32'd10);
        rd(udlr_pkg::ADDR_T1_CNT, T1F);
        apb(1'b0, 12'h0F0, 32'h0);
        check({31'h0, e}, 32'h1);
        apb(1'b1, udlr_pkg::ADDR_CTRL, 32'h1);
        pulse_bus();
        pulse_desc();
        rd(udlr_pkg::ADDR_STATUS, 32'(udlr_pkg::UDLR_IDLE));
        for (int m = 0; m < 4; m++) round(m);
        final_report();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        final_report();
    end
endmodule // test_usb_dma_lockup_recovery
`default_nettype wire
